// file: logic/bct_ctrl.sv
// trigger cycle controller top: registers, cycle control, code output
// Operation
// RULE_01 - fixed mode sends exactly the first one to eight valid codes
// RULE_02 - per-buffer mode sends one code per enabled code buffer
// RULE_03 - all-codes mode sends every valid code of the cycle
// RULE_04 - serial mode opens on start char and closes on end char
// RULE_05 - start and end chars are one full byte each, null allowed
// RULE_06 - host must not use escape as start or end character
// RULE_07 - timed continuous mode suppresses the same code until timeout
// RULE_08 - timeout 999 suppresses the same code until another code fires
// RULE_09 - timed continuous mode never emits a no-read
// RULE_10 - transmit continuous mode sends every code, no suppression
// RULE_11 - hardware mode bounds the cycle by the trigger input
// RULE_12 - standard polarity: high trigger level means enabled
// RULE_13 - inverted polarity: low trigger level means enabled
// RULE_14 - decode threshold holds 0 to 99, reset value 3
// RULE_15 - continuous modes send a code when its count hits threshold
// RULE_16 - trigger modes compare counts with threshold at cycle end
// RULE_17 - threshold zero behaves as threshold one
// RULE_18 - no valid code at cycle end gives a no-read result
// RULE_19 - host keeps threshold at 5 or below for two codes per cycle
// RULE_20 - trigger timer in 10 ms units, 0 disables, ends the cycle
// RULE_21 - trigger input synchronised before polarity and edge detect
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`default_nettype none
module bct_ctrl #(
  parameter int TICK_CYC = bct_pkg::TICK_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        trig_in,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_char_in,
  input  wire logic        dec_valid_in,
  input  wire logic [2:0]  dec_buf_in,
  input  wire logic [15:0] dec_sig_in,
  output logic             tx_valid_out,
  output logic [2:0]       tx_buf_out,
  output logic             tx_noread_out,
  input  wire logic        tx_ready_in,
  output logic             setup_req_out,
  output logic             cycle_active_out
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]      mode;
    logic            inv;
    logic [1:0]      cmode;
    logic [2:0]      fixn;
    logic [7:0]      sor;
    logic [7:0]      eor;
    logic [6:0]      win;
    logic [6:0]      ttim;
    logic [9:0]      tout;
    logic [7:0]      bufen;
    bct_pkg::bct_cyc_t cyc;
    logic [7:0][6:0] cnt;
    logic [17:0]     pre;
    logic [6:0]      tunits;
    logic [9:0]      hunits;
    logic            hold;
    logic [15:0]     last_sig;
    logic [7:0]      pend;
    logic            nord;
    logic            txv;
    logic [2:0]      txb;
    logic            txn;
    logic            wr;
    logic [31:0]     rdata;
    logic            setup;
    logic            act;
  } bct_st_t;

  bct_st_t s_r;
  bct_st_t s_nxt;
  logic    t_rise;
  logic    t_fall;

  bct_trig_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .trig_in    (trig_in),
    .inv_in     (s_r.inv),
    .on_out     (),
    .rise_out   (t_rise),
    .fall_out   (t_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // threshold zero counts as one
  function automatic logic [6:0] win_eff(input logic [6:0] w);
    return (w == 7'h00) ? 7'h01 : w; // RULE_17
  endfunction

  // keeps the lowest n+1 set bits of a mask
  function automatic logic [7:0] first_n(input logic [7:0] m,
                                         input logic [2:0] n);
    logic [7:0] r;
    logic [3:0] k;
    r = 8'h00;
    k = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i] && (k <= {1'b0, n})) begin
        r[i] = 1'b1;
        k    = k + 4'h1;
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] low_idx(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic       tick;
  logic       trig_mode;
  logic       start_cyc;
  logic       end_cyc;
  logic [7:0] valid_m;
  logic [7:0] sel_m;
  logic [7:0] set_m;
  logic [7:0] clr_m;
  logic [6:0] cnt_inc;
  logic       fire;
  logic [31:0] wv;
  logic       nord_set;

  always_comb begin
    s_nxt     = s_r;
    wv        = 32'h0000_0000;
    set_m     = 8'h00;
    clr_m     = 8'h00;
    valid_m   = 8'h00;
    sel_m     = 8'h00;
    cnt_inc   = 7'h00;
    fire      = 1'b0;
    start_cyc = 1'b0;
    end_cyc   = 1'b0;
    nord_set  = 1'b0;
    trig_mode = (s_r.mode == bct_pkg::MODE_SERIAL) ||
                (s_r.mode == bct_pkg::MODE_HW);
    tick      = (s_r.pre == 18'(TICK_CYC - 1));
    s_nxt.pre = tick ? 18'h00000 : s_r.pre + 18'h00001;
    s_nxt.setup = 1'b0;

    // bus slave: one wait cycle, then the answer
    s_nxt.wr = 1'b1;
    if ((avs_read_in || avs_write_in) && s_r.wr) begin
      s_nxt.wr = 1'b0;
      case (avs_address_in)
        bct_pkg::OFF_CTRL:   s_nxt.rdata = {24'h000000, s_r.fixn, s_r.cmode,
                                            s_r.inv, s_r.mode};
        bct_pkg::OFF_CHARS:  s_nxt.rdata = {16'h0000, s_r.eor, s_r.sor};
        bct_pkg::OFF_WIN:    s_nxt.rdata = {25'h0000000, s_r.win};
        bct_pkg::OFF_TIMER:  s_nxt.rdata = {25'h0000000, s_r.ttim};
        bct_pkg::OFF_TOUT:   s_nxt.rdata = {22'h000000, s_r.tout};
        bct_pkg::OFF_BUFEN:  s_nxt.rdata = {24'h000000, s_r.bufen};
        bct_pkg::OFF_STATUS: s_nxt.rdata = {16'h0000, s_r.pend, 6'h00,
                                            s_r.nord, s_r.act};
        default:             s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_in && !s_r.wr) begin
      case (avs_address_in)
        bct_pkg::OFF_CTRL: begin
          wv = be_merge({24'h000000, s_r.fixn, s_r.cmode, s_r.inv,
                         s_r.mode}, avs_writedata_in, avs_byteenable_in);
          s_nxt.mode  = wv[bct_pkg::CTRL_MODE_LSB +: 2];
          s_nxt.inv   = wv[bct_pkg::CTRL_INV_BIT];
          s_nxt.cmode = wv[bct_pkg::CTRL_CMODE_LSB +: 2];
          s_nxt.fixn  = wv[bct_pkg::CTRL_FIXN_LSB +: 3];
        end
        bct_pkg::OFF_CHARS: begin
          wv = be_merge({16'h0000, s_r.eor, s_r.sor}, avs_writedata_in,
                        avs_byteenable_in);
          s_nxt.sor = wv[7:0]; // RULE_05
          s_nxt.eor = wv[bct_pkg::CHARS_EOR_LSB +: 8]; // RULE_05
        end
        bct_pkg::OFF_WIN: begin
          wv = be_merge({25'h0000000, s_r.win}, avs_writedata_in,
                        avs_byteenable_in);
          if (wv[31:0] <= {25'h0000000, bct_pkg::MAX_99}) begin
            s_nxt.win = wv[6:0]; // RULE_14
          end
        end
        bct_pkg::OFF_TIMER: begin
          wv = be_merge({25'h0000000, s_r.ttim}, avs_writedata_in,
                        avs_byteenable_in);
          if (wv[31:0] <= {25'h0000000, bct_pkg::MAX_99}) begin
            s_nxt.ttim = wv[6:0]; // RULE_20
          end
        end
        bct_pkg::OFF_TOUT: begin
          wv = be_merge({22'h000000, s_r.tout}, avs_writedata_in,
                        avs_byteenable_in);
          if (wv[31:0] <= {22'h000000, bct_pkg::MAX_999}) begin
            s_nxt.tout = wv[9:0];
          end
        end
        bct_pkg::OFF_BUFEN: begin
          wv = be_merge({24'h000000, s_r.bufen}, avs_writedata_in,
                        avs_byteenable_in);
          s_nxt.bufen = wv[7:0];
        end
        default: begin
          wv = 32'h0000_0000;
        end
      endcase
    end

    // escape always means setup, it never acts as a trigger char
    if (rx_valid_in && rx_char_in == bct_pkg::ESC_CHAR) begin
      s_nxt.setup = 1'b1; // RULE_06
    end

    // cycle open and close
    if (s_r.mode == bct_pkg::MODE_SERIAL && rx_valid_in &&
        rx_char_in != bct_pkg::ESC_CHAR) begin
      start_cyc = (rx_char_in == s_r.sor); // RULE_04
      end_cyc   = (rx_char_in == s_r.eor); // RULE_04
    end else if (s_r.mode == bct_pkg::MODE_HW) begin
      start_cyc = t_rise; // RULE_11
      end_cyc   = t_fall; // RULE_11
    end
    if (tick && s_r.cyc == bct_pkg::CYC_ACT && s_r.ttim != 7'h00 &&
        s_r.tunits + 7'h01 >= s_r.ttim) begin
      end_cyc = 1'b1; // RULE_20
    end
    if (tick && s_r.cyc == bct_pkg::CYC_ACT) begin
      s_nxt.tunits = s_r.tunits + 7'h01;
    end

    case (s_r.cyc)
      bct_pkg::CYC_IDLE: begin
        if (trig_mode && start_cyc) begin
          s_nxt.cyc    = bct_pkg::CYC_ACT;
          s_nxt.cnt    = '0;
          s_nxt.tunits = 7'h00;
        end
      end
      bct_pkg::CYC_ACT: begin
        if (!trig_mode) begin
          s_nxt.cyc = bct_pkg::CYC_IDLE;
        end else if (end_cyc) begin
          s_nxt.cyc = bct_pkg::CYC_EVAL;
        end
      end
      bct_pkg::CYC_EVAL: begin
        // counts are judged only now, once the cycle has closed
        for (int i = 0; i < 8; i++) begin
          valid_m[i] = (s_r.cnt[i] >= win_eff(s_r.win)); // RULE_16
        end
        case (s_r.cmode)
          bct_pkg::CM_FIXED:  sel_m = first_n(valid_m, s_r.fixn); // RULE_01
          bct_pkg::CM_PERBUF: sel_m = valid_m & s_r.bufen; // RULE_02
          default:            sel_m = valid_m; // RULE_03
        endcase
        set_m = sel_m;
        if (sel_m == 8'h00) begin
          s_nxt.nord = 1'b1; // RULE_18
          nord_set   = 1'b1;
        end
        s_nxt.cyc = bct_pkg::CYC_IDLE;
      end
      default: begin
        s_nxt.cyc = bct_pkg::CYC_IDLE;
      end
    endcase
    s_nxt.act = (s_nxt.cyc == bct_pkg::CYC_ACT) || !trig_mode;

    // decode counting; continuous modes fire on reaching the threshold
    if (dec_valid_in && (s_r.cyc == bct_pkg::CYC_ACT || !trig_mode)) begin
      cnt_inc = (s_r.cnt[dec_buf_in] >= bct_pkg::MAX_99) ? bct_pkg::MAX_99 :
                s_r.cnt[dec_buf_in] + 7'h01;
      s_nxt.cnt[dec_buf_in] = cnt_inc;
      // a count left above a lowered threshold must still fire
      if (!trig_mode && cnt_inc >= win_eff(s_r.win)) begin
        fire = 1'b1; // RULE_15
        s_nxt.cnt[dec_buf_in] = 7'h00;
      end
    end
    if (s_r.mode == bct_pkg::MODE_CONT_T && s_r.hold && tick &&
        s_r.tout != bct_pkg::MAX_999) begin
      s_nxt.hunits = s_r.hunits + 10'h001;
      if (s_r.hunits + 10'h001 >= s_r.tout) begin
        s_nxt.hold = 1'b0; // RULE_07
      end
    end
    if (fire) begin
      if (s_r.mode == bct_pkg::MODE_CONT_X) begin
        set_m[dec_buf_in] = 1'b1; // RULE_10
      end else if (!(s_r.hold && dec_sig_in == s_r.last_sig)) begin
        // a different code also ends a 999 hold here
        set_m[dec_buf_in] = 1'b1; // RULE_07 RULE_08
        s_nxt.last_sig    = dec_sig_in;
        s_nxt.hold        = (s_r.tout != 10'h000);
        s_nxt.hunits      = 10'h000;
      end
    end
    if (!trig_mode) begin
      s_nxt.nord = 1'b0; // RULE_09
    end

    // output stage, one code per handshake, lowest buffer first
    if (!s_r.txv || tx_ready_in) begin
      s_nxt.txv = 1'b0;
      s_nxt.txn = 1'b0;
      if (s_r.pend != 8'h00) begin
        s_nxt.txv = 1'b1;
        s_nxt.txb = low_idx(s_r.pend);
        clr_m[low_idx(s_r.pend)] = 1'b1;
      end else if (s_r.nord) begin
        s_nxt.txv  = 1'b1;
        s_nxt.txn  = 1'b1;
        s_nxt.txb  = 3'h0;
        // a no-read raised in this very cycle survives the send
        s_nxt.nord = nord_set & trig_mode;
      end
    end
    // a new request beats a clear in the same cycle
    s_nxt.pend = (s_r.pend & ~clr_m) | set_m;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r       <= '0;
      s_r.mode  <= bct_pkg::RST_MODE;
      s_r.inv   <= bct_pkg::RST_INV;
      s_r.cmode <= bct_pkg::RST_CMODE;
      s_r.fixn  <= bct_pkg::RST_FIXN;
      s_r.sor   <= bct_pkg::RST_SOR;
      s_r.eor   <= bct_pkg::RST_EOR;
      s_r.win   <= bct_pkg::RST_WIN; // RULE_14
      s_r.ttim  <= bct_pkg::RST_TIMER;
      s_r.tout  <= bct_pkg::RST_TOUT;
      s_r.bufen <= bct_pkg::RST_BUFEN;
      s_r.cyc   <= bct_pkg::CYC_IDLE;
      s_r.wr    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_out    = s_r.rdata;
  assign avs_waitrequest_out = s_r.wr;
  assign tx_valid_out        = s_r.txv;
  assign tx_buf_out          = s_r.txb;
  assign tx_noread_out       = s_r.txn;
  assign setup_req_out       = s_r.setup;
  assign cycle_active_out    = s_r.act;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_hw_open;
    s_r.mode == bct_pkg::MODE_HW && t_rise && s_r.cyc == bct_pkg::CYC_IDLE;
  endsequence
  property p_hw_open;
    s_hw_open |=> s_r.cyc == bct_pkg::CYC_ACT ##0 cycle_active_out;
  endproperty
  a_hw_open: assert property (p_hw_open) else $error("no hw open"); // RULE_11
  property p_hw_close;
    s_r.mode == bct_pkg::MODE_HW && $past(s_r.mode) == bct_pkg::MODE_HW &&
    t_fall && s_r.cyc == bct_pkg::CYC_ACT |=> s_r.cyc == bct_pkg::CYC_EVAL;
  endproperty
  a_hw_close: assert property (p_hw_close) else $error("no close"); // RULE_11
  property p_ser_open;
    s_r.mode == bct_pkg::MODE_SERIAL && s_r.cyc == bct_pkg::CYC_IDLE &&
    rx_valid_in && rx_char_in == s_r.sor && rx_char_in != bct_pkg::ESC_CHAR
    |=> s_r.cyc == bct_pkg::CYC_ACT;
  endproperty
  a_ser_open: assert property (p_ser_open) else $error("no open"); // RULE_04
  property p_ser_hold;
    s_r.mode == bct_pkg::MODE_SERIAL && $past(s_r.mode) == s_r.mode &&
    s_r.cyc == bct_pkg::CYC_ACT && !(rx_valid_in && rx_char_in == s_r.eor)
    && !(s_r.ttim != 7'h00) |=> s_r.cyc == bct_pkg::CYC_ACT;
  endproperty
  a_ser_hold: assert property (p_ser_hold) else $error("early end"); // RULE_04
  property p_noread_sel;
    s_r.cyc == bct_pkg::CYC_EVAL && sel_m == 8'h00 |=> s_r.nord;
  endproperty
  a_noread_sel: assert property (p_noread_sel) else $error("lost"); // RULE_18
  property p_cont_noread;
    s_r.mode == bct_pkg::MODE_CONT_T |-> !(tx_valid_out && tx_noread_out)
      or $past(s_r.mode) != bct_pkg::MODE_CONT_T;
  endproperty
  a_cont_noread: assert property (p_cont_noread) // RULE_09
    else $error("cont no-read");
  property p_win_zero;
    s_r.cyc == bct_pkg::CYC_EVAL && s_r.win == 7'h00 |->
      valid_m[0] == (s_r.cnt[0] != 7'h00) &&
      valid_m[2] == (s_r.cnt[2] != 7'h00);
  endproperty
  a_win_zero: assert property (p_win_zero) else $error("win zero"); // RULE_17
  property p_win_range;
    s_r.win <= bct_pkg::MAX_99 && s_r.ttim <= bct_pkg::MAX_99;
  endproperty
  a_win_range: assert property (p_win_range) // RULE_14 RULE_20
    else $error("range broken");
  property p_fixed_cnt;
    s_r.cyc == bct_pkg::CYC_EVAL && s_r.cmode == bct_pkg::CM_FIXED |->
      $countones(sel_m) <= int'(s_r.fixn) + 1;
  endproperty
  a_fixed_cnt: assert property (p_fixed_cnt) else $error("excess"); // RULE_01
  property p_xmit_fire;
    s_r.mode == bct_pkg::MODE_CONT_X && fire |=> s_r.pend[$past(dec_buf_in)];
  endproperty
  a_xmit_fire: assert property (p_xmit_fire) // RULE_10 RULE_15
    else $error("code not queued");
endmodule // bct_ctrl
`default_nettype wire

// file: logic/bct_pkg.sv
// package: constants and types of the trigger cycle controller
`default_nettype none
package bct_pkg;
  // clock and timer base
  localparam int CLK_HZ         = 25_000_000;
  localparam int TICK_MS        = 10;
  localparam int TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
  localparam int SYNC_STAGES    = 2;
  // register byte offsets
  localparam logic [4:0] OFF_CTRL    = 5'h00;
  localparam logic [4:0] OFF_CHARS   = 5'h04;
  localparam logic [4:0] OFF_WIN     = 5'h08;
  localparam logic [4:0] OFF_TIMER   = 5'h0c;
  localparam logic [4:0] OFF_TOUT    = 5'h10;
  localparam logic [4:0] OFF_BUFEN   = 5'h14;
  localparam logic [4:0] OFF_STATUS  = 5'h18;
  // ctrl, chars and status fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_INV_BIT   = 2;
  localparam int CTRL_CMODE_LSB = 3;
  localparam int CTRL_FIXN_LSB  = 5;
  localparam int CHARS_EOR_LSB  = 8;
  localparam int STAT_NORD_BIT  = 1;
  localparam int STAT_PEND_LSB  = 8;
  // reset values
  localparam logic [1:0] RST_MODE   = 2'h3;
  localparam logic       RST_INV    = 1'b0;
  localparam logic [1:0] RST_CMODE  = 2'h0;
  localparam logic [2:0] RST_FIXN   = 3'h0;
  localparam logic [7:0] RST_SOR    = 8'h02;
  localparam logic [7:0] RST_EOR    = 8'h03;
  localparam logic [6:0] RST_WIN    = 7'h03;
  localparam logic [6:0] RST_TIMER  = 7'h00;
  localparam logic [9:0] RST_TOUT   = 10'h000;
  localparam logic [7:0] RST_BUFEN  = 8'hff;
  // limits and special values
  localparam logic [6:0] MAX_99     = 7'h63;
  localparam logic [9:0] MAX_999    = 10'h3e7;
  localparam logic [7:0] ESC_CHAR   = 8'h1b;
  // trigger modes
  localparam logic [1:0] MODE_SERIAL = 2'h0;
  localparam logic [1:0] MODE_CONT_T = 2'h1;
  localparam logic [1:0] MODE_CONT_X = 2'h2;
  localparam logic [1:0] MODE_HW     = 2'h3;
  // codes per cycle modes
  localparam logic [1:0] CM_FIXED  = 2'h0;
  localparam logic [1:0] CM_PERBUF = 2'h1;
  localparam logic [1:0] CM_ALL    = 2'h2;
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ACT  = 2'b01,
    CYC_EVAL = 2'b11
  } bct_cyc_t;
endpackage : bct_pkg
`default_nettype wire

// file: logic/bct_trig_sync.sv
// trigger input synchroniser, polarity select and edge detect
`default_nettype none
module bct_trig_sync (
  input  wire logic sys_clk_in,
  input  wire logic resetn_in,
  input  wire logic trig_in,
  input  wire logic inv_in,
  output logic      on_out,
  output logic      rise_out,
  output logic      fall_out
);
  typedef struct packed {
    logic [bct_pkg::SYNC_STAGES-1:0] sy;
    logic on;
    logic rise;
    logic fall;
  } bct_ts_t;
  bct_ts_t s_r;
  bct_ts_t s_nxt;
  logic    lvl;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.sy = {s_r.sy[bct_pkg::SYNC_STAGES-2:0], trig_in}; // RULE_21
    // only the last stage is looked at
    lvl        = s_r.sy[bct_pkg::SYNC_STAGES-1] ^ inv_in; // RULE_12 RULE_13
    s_nxt.on   = lvl;
    s_nxt.rise = lvl & ~s_r.on; // RULE_21
    s_nxt.fall = ~lvl & s_r.on; // RULE_21
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign on_out   = s_r.on;
  assign rise_out = s_r.rise;
  assign fall_out = s_r.fall;
endmodule // bct_trig_sync
`default_nettype wire

// file: logic/bct_unused_guard.sv
// reserved file: holds no logic of the trigger cycle controller
`default_nettype none
`default_nettype wire

// file: sim/bct_ctrl_tb_top.sv
// self-checking bench of the trigger cycle controller
`default_nettype none
module bct_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, resetn, rd, wr, wreq, dv;
  logic        trig, rxv, tx_v, tx_nr, tx_rdy, setup, act;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic [2:0]  dbuf, tx_buf;
  logic [15:0] dsig;
  logic [7:0]  rxc;
  int          n_fail = 0;
  int          checked = 0;
  logic [31:0] seen[$];
  int          exp_q[$];
  int win_t[6]   = '{0, 3, 3, 4, 3, 3};
  int ctrl_t[6]  = '{8'h03, 8'h07, 8'h20, 8'h13, 8'h13, 8'h0b};
  int mask_t[6]  = '{8'h04, 8'h00, 8'h29, 8'h01, 8'h92, 8'h07};
  int bufen_t[6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h05};
  bct_ctrl #(.TICK_CYC(20)) i_bct_ctrl (
    .sys_clk_in(sys_clk), .resetn_in(resetn),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .trig_in(trig), .rx_valid_in(rxv), .rx_char_in(rxc),
    .dec_valid_in(dv), .dec_buf_in(dbuf), .dec_sig_in(dsig),
    .tx_valid_out(tx_v), .tx_buf_out(tx_buf), .tx_noread_out(tx_nr),
    .tx_ready_in(tx_rdy), .setup_req_out(setup),
    .cycle_active_out(act));
  bct_host_model i_bct_host_model (
    .clk_in(sys_clk), .trig_out(trig), .rx_valid_out(rxv),
    .rx_char_out(rxc), .tx_ready_out(tx_rdy));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // a no-read is logged as 8, a code as its buffer index
  always @(posedge sys_clk)
    if (resetn && tx_v && tx_rdy)
      seen.push_back(tx_nr ? 32'h8 : {29'h0, tx_buf});
  //////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    i = 0;
    // the wait must take exactly two cycles; only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
      i++;
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk("bus_wait", i, 32'h2);
  endtask
  task automatic wr32(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("reg_read", q, e);
  endtask
  task automatic dec(input logic [2:0] b, input logic [15:0] s);
    @(posedge sys_clk);
    dv <= 1'b1;
    dbuf <= b;
    dsig <= s;
    @(posedge sys_clk);
    dv <= 1'b0;
  endtask
  // spacing lets a sent code settle before the next decode
  task automatic dec_w(input logic [2:0] b, input logic [15:0] s);
    dec(b, s);
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic wait_act(input logic v);
    int i;
    for (i = 0; i < 100 && act !== v; i++) @(posedge sys_clk);
    chk("cycle_active", {31'h0, act}, {31'h0, v});
  endtask
  task automatic cmp_q(string nm);
    int i;
    repeat (60) @(posedge sys_clk);
    chk("tx_count", seen.size(), exp_q.size());
    for (i = 0; i < exp_q.size() && i < seen.size(); i++)
      chk("tx_code", seen[i], exp_q[i]);
    $display("test %s done", nm);
    seen.delete();
    exp_q.delete();
  endtask
  // one trigger cycle from the table, three decodes per marked buffer
  task automatic cyc(int k);
    int w, b, n;
    logic inv;
    logic [31:0] c;
    c = ctrl_t[k];
    inv = c[2];
    w = (win_t[k] < 1) ? 1 : win_t[k];
    n = 0;
    // park in serial mode so a polarity change opens no cycle
    wr32(5'h00, 32'h0);
    i_bct_host_model.set_trig(inv);
    wr32(5'h08, win_t[k]);
    wr32(5'h14, bufen_t[k]);
    wr32(5'h00, c);
    if (c[1:0] == 2'h0) i_bct_host_model.send_char(8'h00);
    else i_bct_host_model.set_trig(!inv);
    wait_act(1'b1);
    for (b = 0; b < 8; b++)
      if (mask_t[k][b]) repeat (3) dec(b[2:0], 16'(b));
    if (c[1:0] == 2'h0) i_bct_host_model.send_char(8'h7e);
    else i_bct_host_model.set_trig(inv);
    wait_act(1'b0);
    for (b = 0; b < 8; b++)
      if (mask_t[k][b] && 3 >= w)
        case (c[4:3])
          2'h0: if (n <= c[7:5]) begin
            exp_q.push_back(b);
            n++;
          end
          2'h1: if (bufen_t[k][b]) exp_q.push_back(b);
          default: exp_q.push_back(b);
        endcase
    if (exp_q.size() == 0) exp_q.push_back(8);
    cmp_q("trigger_cycle");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end
  initial begin
    logic [15:0] sa;
    int k;
    void'($urandom(32'h074dfb4a));
    resetn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    dv = 1'b0;
    dbuf = 3'h0;
    dsig = 16'h0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk(5'h00, 32'h3);
    rdchk(5'h04, 32'h0302);
    rdchk(5'h08, 32'h3);
    rdchk(5'h14, 32'hff);
    rdchk(5'h1c, 32'h0);
    rdchk(5'h18, 32'h0);
    wr32(5'h08, 32'h64);
    rdchk(5'h08, 32'h3);
    wr32(5'h08, 32'h63);
    rdchk(5'h08, 32'h63);
    wr32(5'h04, 32'h7e00);
    rdchk(5'h04, 32'h7e00);
    i_bct_host_model.send_char(8'h1b);
    @(posedge sys_clk);
    chk("setup_req", {31'h0, setup}, 32'h1);
    $display("test registers done");
    for (k = 0; k < 6; k++) cyc(k);
    // trigger stays enabled, so only the timer can close this cycle
    wr32(5'h0c, 32'h2);
    i_bct_host_model.set_trig(1'b1);
    wait_act(1'b1);
    wait_act(1'b0);
    i_bct_host_model.set_trig(1'b0);
    wr32(5'h0c, 32'h0);
    exp_q = '{8};
    cmp_q("trigger_timer");
    wr32(5'h14, 32'hff);
    wr32(5'h08, 32'h2);
    wr32(5'h00, 32'h2);
    repeat (4) dec_w(3'h6, 16'h0abc);
    exp_q = '{6, 6};
    cmp_q("continuous_transmit");
    sa = $urandom;
    wr32(5'h10, 32'h3e7);
    wr32(5'h08, 32'h1);
    wr32(5'h00, 32'h1);
    dec_w(3'h0, sa);
    dec_w(3'h0, sa);
    dec_w(3'h1, ~sa);
    dec_w(3'h0, sa);
    exp_q = '{0, 1, 0};
    cmp_q("continuous_timed_999");
    wr32(5'h10, 32'h2);
    // the repeat comes well inside the shortest possible hold
    dec(3'h2, sa ^ 16'h5a5a);
    dec_w(3'h2, sa ^ 16'h5a5a);
    repeat (150) @(posedge sys_clk);
    dec_w(3'h2, sa ^ 16'h5a5a);
    exp_q = '{2, 2};
    cmp_q("continuous_timed");
    close_out();
  end
endmodule // bct_ctrl_tb_top
`default_nettype wire

// file: sim/bct_host_model.sv
// host link and trigger source model on the controller's far side
`default_nettype none
module bct_host_model (
  input  wire logic  clk_in,
  output logic       trig_out,
  output logic       rx_valid_out,
  output logic [7:0] rx_char_out,
  output logic       tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    trig_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_char_out = 8'h55;
    tx_ready_out = 1'b0;
  end
  // sink stalls about one cycle in four, so pending codes must hold
  always @(posedge clk_in) tx_ready_out <= ($urandom % 4) != 0;
  // presence level, held for as long as the code is present
  task automatic set_trig(input logic v);
    @(posedge clk_in) trig_out <= v;
  endtask
  // one char per pulse; escape is never sent as start or end
  task automatic send_char(input logic [7:0] c);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_char_out <= c;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_char_out <= ~c;
  endtask
endmodule // bct_host_model
`default_nettype wire
